// ---- bench/pars_station.sv ----
// Management station model on the PHY register port
module pars_station (
    input  wire         clk_sys_i,
    input  wire         miim_ack_o,
    input  wire  [15:0] miim_rdata_o,
    output logic        req_o,
    output logic        we_o,
    output logic [4:0]  phy_o,
    output logic [4:0]  reg_o,
    output logic [15:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req_o, we_o, phy_o, reg_o, wdata_o} = '0;
    // One-cycle request; released data is inverted so stale values never match
    task automatic access(input logic we, input logic [4:0] phy, input logic [4:0] ra,
                          input logic [15:0] wd, output logic [15:0] rd, output logic ak);
        @(negedge clk_sys_i);
        req_o <= 1'b1;
        we_o <= we;
        phy_o <= phy;
        reg_o <= ra;
        wdata_o <= wd;
        @(negedge clk_sys_i);
        req_o <= 1'b0;
        wdata_o <= ~wd;
        ak = miim_ack_o;
        rd = miim_rdata_o;
    endtask
    task automatic poll(input logic [4:0] phy, output logic [15:0] rd, output logic ok);
        logic ak;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            access(1'b0, phy, 5'h1d, 16'h0000, rd, ak);
            ok = (rd[15] === 1'b0);
        end
    endtask
endmodule

// ---- bench/pars_top_monitor.sv ----
// Port checker for the PHY ability register bank
module pars_monitor (
    input wire        clk_sys_i, rst_b_i, miim_req_i, miim_we_i, miim_ack_o,
    input wire        sw_req_i, sw_we_i,
    input wire [4:0]  phy_select_address_i, register_select_address_i,
    input wire [15:0] miim_wdata_i, miim_rdata_o,
    input wire [9:0]  adv_ability_o,
    input wire [1:0]  cdiag_fe_start_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    wire to_adv = miim_req_i && phy_select_address_i == 5'h01
                  && register_select_address_i == 5'h04;
    sequence s_taken;
        miim_req_i;
    endsequence
    sequence s_answer;
        ##1 miim_ack_o;
    endsequence
    a_ack_follows_req: assert property (s_taken |-> s_answer)
        else $error("ack missing after request");
    a_no_spur_ack: assert property (!miim_req_i |=> !miim_ack_o)
        else $error("ack without request");
    a_adv_reset: assert property ($rose(rst_b_i) |-> adv_ability_o == 10'h3ff)
        else $error("advertised abilities not all set after reset");
    a_adv_write: assert property (to_adv && miim_we_i |=> adv_ability_o[4:0] ==
        {$past(miim_wdata_i[10]), $past(miim_wdata_i[8:5])})
        else $error("advertised abilities differ from written bits");
    a_adv_readback: assert property (to_adv && !miim_we_i |=> miim_rdata_o ==
        {5'h00, $past(adv_ability_o[4]), 1'b0, $past(adv_ability_o[3:0]), 5'h01})
        else $error("advert readback wrong");
    a_phy_isolated: assert property (to_adv && miim_we_i |=>
        $stable(adv_ability_o[9:5]))
        else $error("write to first PHY changed second");
    a_unmapped_read: assert property (miim_req_i && !miim_we_i && phy_select_address_i != 5'h01 &&
        phy_select_address_i != 5'h02 |=> miim_rdata_o == 16'h0000)
        else $error("unmapped PHY read not zero");
    a_start_pulse: assert property (cdiag_fe_start_o[0] |=> !cdiag_fe_start_o[0])
        else $error("test launch longer than one cycle");
    a_start_cause: assert property ($rose(cdiag_fe_start_o[0]) |->
        $past(miim_req_i && miim_we_i) || $past(sw_req_i && sw_we_i))
        else $error("test launched without a write");
endmodule
bind pars_top pars_monitor pars_monitor_inst (
    .clk_sys_i                 (clk_sys_i),
    .rst_b_i                   (rst_b_i),
    .miim_req_i                (miim_req_i),
    .miim_we_i                 (miim_we_i),
    .miim_ack_o                (miim_ack_o),
    .sw_req_i                  (sw_req_i),
    .sw_we_i                   (sw_we_i),
    .phy_select_address_i      (phy_select_address_i),
    .register_select_address_i (register_select_address_i),
    .miim_wdata_i              (miim_wdata_i),
    .miim_rdata_o              (miim_rdata_o),
    .adv_ability_o             (adv_ability_o),
    .cdiag_fe_start_o          (cdiag_fe_start_o)
);

// ---- bench/tb_pars_top.sv ----
// Self-checking bench for the PHY ability register bank
module tb_pars_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, sw_req, sw_we, mreq, mwe, ack, sack;
    logic [7:0] sw_addr, sw_wdata, sw_rdata;
    logic [4:0] phy, ra;
    logic [15:0] mwd, mrd;
    logic [9:0] p_ab, adv;
    logic [1:0] p_upd, fe_done, fe_short, fe_start;
    logic [3:0] fe_res;
    logic [17:0] fe_cnt;
    int num_errors = 0;
    int n_checks = 0;
    pars_top #(.CDIAG_TIMEOUT(20)) pars_top_inst (.clk_sys_i(clk), .rst_b_i(rst_b),
        .miim_req_i(mreq), .miim_we_i(mwe), .phy_select_address_i(phy),
        .register_select_address_i(ra), .miim_wdata_i(mwd), .miim_rdata_o(mrd),
        .miim_ack_o(ack), .sw_req_i(sw_req), .sw_we_i(sw_we), .sw_addr_i(sw_addr),
        .sw_wdata_i(sw_wdata), .sw_rdata_o(sw_rdata), .sw_ack_o(sack),
        .adv_ability_o(adv), .partner_ability_i(p_ab), .partner_update_i(p_upd),
        .cdiag_fe_start_o(fe_start), .cdiag_fe_done_i(fe_done),
        .cdiag_fe_result_i(fe_res), .cdiag_fe_short_i(fe_short), .cdiag_fe_count_i(fe_cnt));
    pars_station pars_station_inst (.clk_sys_i(clk), .miim_ack_o(ack), .miim_rdata_o(mrd),
        .req_o(mreq), .we_o(mwe), .phy_o(phy), .reg_o(ra), .wdata_o(mwd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic mm(input logic we, input logic [4:0] p, input logic [4:0] r,
                      input logic [15:0] wd, output logic [15:0] rd);
        logic ak;
        pars_station_inst.access(we, p, r, wd, rd, ak);
        check("miim ack", {15'h0, ak}, 16'h0001);
    endtask
    task automatic sw(input logic we, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
        @(negedge clk);
        {sw_req, sw_we, sw_addr, sw_wdata} <= {1'b1, we, a, wd};
        @(negedge clk);
        sw_req <= 1'b0;
        sw_wdata <= ~wd;
        check("sw ack", {15'h0, sack}, 16'h0001);
        rd = sw_rdata;
    endtask
    task automatic t_reset;
        logic [15:0] rd;
        logic [7:0] sr;
        for (int p = 1; p <= 2; p++) begin
            mm(0, p, 5'h04, 0, rd); check("adv", rd, 16'h05e1);
            mm(0, p, 5'h05, 0, rd); check("partner", rd, 16'h0000);
            mm(0, p, 5'h1d, 0, rd); check("cdiag", rd, 16'h0000);
        end
        check("adv pins", {6'h0, adv}, 16'h03ff);
        sw(0, 8'h1c, 0, sr); check("sw adv", {8'h0, sr}, 16'h001f);
        $display("test reset done");
    endtask
    task automatic t_adv;
        int b[5] = '{10, 8, 7, 6, 5};
        logic [15:0] rd;
        logic [7:0] sr;
        for (int i = 0; i < 5; i++) begin
            mm(1, 5'h01, 5'h04, 16'h0001 << b[i], rd);
            mm(0, 5'h01, 5'h04, 0, rd); check("adv bit", rd, (16'h0001 << b[i]) | 1);
            check("adv pin", {11'h0, adv[4:0]}, 16'h0010 >> i);
        end
        mm(1, 5'h01, 5'h04, 16'hffff, rd);
        mm(0, 5'h01, 5'h04, 0, rd); check("adv ro bits", rd, 16'h05e1);
        mm(1, 5'h03, 5'h04, 0, rd);
        mm(0, 5'h03, 5'h04, 0, rd); check("unmapped", rd, 16'h0000);
        sw(1, 8'h1c, 8'h0a, sr);
        mm(0, 5'h01, 5'h04, 0, rd); check("sw alias", rd, 16'h0141);
        sw(1, 8'h2c, 8'h00, sr);
        mm(0, 5'h02, 5'h04, 0, rd); check("phy2 adv", rd, 16'h0001);
        mm(0, 5'h01, 5'h04, 0, rd); check("phy1 kept", rd, 16'h0141);
        $display("test advert done");
    endtask
    task automatic t_partner;
        logic [15:0] rd;
        logic [7:0] sr;
        @(negedge clk);
        {p_ab, p_upd} <= {5'h0a, 5'h15, 2'b11};
        @(negedge clk);
        {p_ab, p_upd} <= {10'h3ff, 2'b00};
        mm(1, 5'h01, 5'h05, 16'hffff, rd);
        mm(0, 5'h01, 5'h05, 0, rd); check("partner1", rd, 16'h04a0);
        mm(0, 5'h02, 5'h05, 0, rd); check("partner2", rd, 16'h0140);
        sw(0, 8'h1e, 0, sr); check("sw partner1", {8'h0, sr}, 16'h0015);
        sw(0, 8'h2e, 0, sr); check("sw partner2", {8'h0, sr}, 16'h000a);
        $display("test partner done");
    endtask
    task automatic cable(input int g, input logic via_sw, input logic [1:0] r, input logic s,
                         input logic [8:0] c, input logic fail);
        logic [15:0] rd;
        logic [15:0] e;
        logic [7:0] sr;
        logic [7:0] base;
        logic ok;
        int n = 0;
        base = (g == 0) ? 8'h1a : 8'h2a;
        if (via_sw) begin
            sw(1, base, 8'h10, sr);
        end else begin
            mm(1, g + 1, 5'h1d, 16'h8000, rd);
        end
        while (fe_start[g] !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("launch", {15'h0, fe_start[g]}, 16'h0001);
        if (n >= 20) print_verdict;
        if (!fail) begin
            // A start while busy must not launch again
            mm(1, g + 1, 5'h1d, 16'h8000, rd);
            check("restart", {15'h0, fe_start[g]}, 16'h0000);
            repeat (3) @(negedge clk);
            fe_res[2*g +: 2] <= r;
            fe_short[g] <= s;
            fe_cnt[9*g +: 9] <= c;
            fe_done[g] <= 1'b1;
            @(negedge clk);
            fe_res[2*g +: 2] <= ~r;
            fe_short[g] <= ~s;
            fe_cnt[9*g +: 9] <= ~c;
            fe_done[g] <= 1'b0;
        end
        e = fail ? 16'h6000 : {1'b0, r, s, 3'b0, c};
        pars_station_inst.poll(g + 1, rd, ok);
        check("done", {15'h0, ok}, 16'h0001);
        if (!ok) print_verdict;
        check("result", rd, e);
        sw(0, base + 8'h01, 0, sr); check("sw count", {8'h0, sr}, {8'h0, e[7:0]});
        sw(0, base, 0, sr);
        check("sw ctrl", {8'h0, sr}, {8'h0, e[12], e[14:13], 4'h0, e[8]});
    endtask
    initial begin
        {rst_b, sw_req, sw_we, sw_addr, sw_wdata, p_ab, p_upd} = '0;
        {fe_done, fe_short, fe_res, fe_cnt} = '0;
        repeat (10) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        t_reset;
        t_adv;
        t_partner;
        for (int r = 0; r < 4; r++) cable(0, 1'b0, r, r[0], 9'h1a5 ^ r, 0);
        cable(1, 1'b1, 2'h2, 1'b1, 9'h0c3, 0);
        cable(0, 1'b0, 2'h3, 0, 0, 1);
        $display("test cable done");
        print_verdict;
    end
endmodule

// ---- rtl/pars_cdiag.v ----
// Cable-diagnostic sequencer for one PHY: start, wait, capture results
`include "pars_defines.vh"

module pars_cdiag #(
    parameter TIMEOUT = `PARS_CD_TIMEOUT
) (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_b_i,
    // Request from the register bank
    input  wire       start_i,
    output wire       busy_o,
    // Analog front end
    output reg        fe_start_o,
    input  wire       fe_done_i,
    input  wire [1:0] fe_result_i,
    input  wire       fe_short_i,
    input  wire [8:0] fe_count_i,
    // Captured results
    output reg  [1:0] result_o,
    output reg        short_o,
    output reg  [8:0] count_o
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    reg [1:0]  state_reg;
    reg [31:0] timer_reg;

    assign busy_o = state_reg[1];

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg  <= ST_IDLE;
            timer_reg  <= 32'h0;
            fe_start_o <= 1'b0;
            result_o   <= `PARS_CD_RES_NORMAL;
            short_o    <= 1'b0;
            count_o    <= `PARS_CD_COUNT_RST;
        end else begin
            fe_start_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_i) begin
                        state_reg  <= ST_RUN;
                        timer_reg  <= 32'h0;
                        fe_start_o <= 1'b1;
                    end
                end
                ST_RUN: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (fe_done_i) begin
                        state_reg <= ST_IDLE;
                        result_o  <= fe_result_i;
                        short_o   <= fe_short_i;
                        count_o   <= fe_count_i;
                    end else if (timer_reg == TIMEOUT - 1) begin
                        // A silent front end must not hang the start bit forever
                        state_reg <= ST_IDLE;
                        result_o  <= `PARS_CD_RES_FAILED;
                        short_o   <= 1'b0;
                        count_o   <= `PARS_CD_COUNT_RST;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- rtl/pars_defines.vh ----
// Constants for the PHY auto-negotiation ability register bank
`ifndef PARS_DEFINES_VH
`define PARS_DEFINES_VH

// Management-interface addressing
`define PARS_PHY_ADDR_BASE     5'h01
`define PARS_REG_ADV           5'h04
`define PARS_REG_PARTNER       5'h05
`define PARS_REG_CDIAG         5'h1d

// Advertisement register fields
`define PARS_ADV_PAUSE_BIT     10
`define PARS_ADV_F100_BIT      8
`define PARS_ADV_H100_BIT      7
`define PARS_ADV_F10_BIT       6
`define PARS_ADV_H10_BIT       5
`define PARS_ADV_SELECTOR      5'h01
`define PARS_ADV_RST           5'h1f
`define PARS_PARTNER_RST       5'h00

// Cable-diagnostic control/status fields
`define PARS_CD_START_BIT      15
`define PARS_CD_RES_HI         14
`define PARS_CD_RES_LO         13
`define PARS_CD_SHORT_BIT      12
`define PARS_CD_RES_NORMAL     2'h0
`define PARS_CD_RES_OPEN       2'h1
`define PARS_CD_RES_SHORT      2'h2
`define PARS_CD_RES_FAILED     2'h3
`define PARS_CD_COUNT_RST      9'h000
`define PARS_CD_TIMEOUT        16384

// Switch-side 8-bit aliases, port 1; port 2 sits one stride higher
`define PARS_SW_CD_CTRL        8'h1a
`define PARS_SW_CD_COUNT       8'h1b
`define PARS_SW_ADV            8'h1c
`define PARS_SW_PARTNER        8'h1e
`define PARS_SW_STRIDE         8'h10
`define PARS_SW_CD_START_BIT   4

`endif

// ---- rtl/pars_top.v ----
// PHY auto-negotiation ability and cable-test registers for two PHYs
//
// What this block does
// - Advertisement bit 10 pause ability, writable, resets one, steers offered pause.
// - Advertisement bit 8 offers 100 full duplex, resets one, aliased in 8-bit register.
// - Advertisement bit 7 offers 100 half duplex, writable, resets one.
// - Advertisement bit 6 offers 10 full duplex, writable, resets one.
// - Advertisement bit 5 offers 10 half duplex, writable, resets one.
// - Partner bit 10 read-only, resets zero, shows partner pause ability.
// - Partner bit 8 read-only, resets zero, shows partner 100 full duplex.
// - Partner bit 7 read-only, resets zero, shows partner 100 half duplex.
// - Partner bit 6 read-only, resets zero, shows partner 10 full duplex.
// - Partner bit 5 read-only, resets zero, shows partner 10 half duplex.
// - Writing one to cable bit 15 starts a test; bit self-clears when done.
// - Start bit reading zero after a test means results are valid.
// - Two-bit result: 00 normal, 01 open, 10 short, 11 failed.
// - Nine-bit fault count; distance is about 0.4 m per count.
`include "pars_defines.vh"

module pars_top #(
    parameter CDIAG_TIMEOUT = `PARS_CD_TIMEOUT
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    // PHY register access (management station side, framing removed)
    input  wire        miim_req_i,
    input  wire        miim_we_i,
    input  wire [4:0]  phy_select_address_i,
    input  wire [4:0]  register_select_address_i,
    input  wire [15:0] miim_wdata_i,
    output reg  [15:0] miim_rdata_o,
    output reg         miim_ack_o,
    // Switch 8-bit register access
    input  wire        sw_req_i,
    input  wire        sw_we_i,
    input  wire [7:0]  sw_addr_i,
    input  wire [7:0]  sw_wdata_i,
    output reg  [7:0]  sw_rdata_o,
    output reg         sw_ack_o,
    // Auto-negotiation engines, five bits per PHY {pause,100F,100H,10F,10H}
    output wire [9:0]  adv_ability_o,
    input  wire [9:0]  partner_ability_i,
    input  wire [1:0]  partner_update_i,
    // Cable-test front ends, one slice per PHY
    output wire [1:0]  cdiag_fe_start_o,
    input  wire [1:0]  cdiag_fe_done_i,
    input  wire [3:0]  cdiag_fe_result_i,
    input  wire [1:0]  cdiag_fe_short_i,
    input  wire [17:0] cdiag_fe_count_i
);

    // Register hit on the PHY side for PHY address phy_want
    function miim_hit;
        input [4:0] phy_sel;
        input [4:0] reg_sel;
        input [4:0] phy_want;
        input [4:0] reg_want;
        begin
            miim_hit = (phy_sel == phy_want) && (reg_sel == reg_want);
        end
    endfunction

    // Register hit on the switch side
    function sw_hit;
        input [7:0] addr;
        input [7:0] base;
        input       port2;
        begin
            sw_hit = (addr == (port2 ? base + `PARS_SW_STRIDE : base));
        end
    endfunction

    wire [9:0]  adv_all;
    wire [9:0]  partner_all;
    wire [1:0]  busy_all;
    wire [3:0]  result_all;
    wire [1:0]  short_all;
    wire [17:0] count_all;

    assign adv_ability_o = adv_all;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : phy
            wire [4:0] phy_addr = (g == 0) ? `PARS_PHY_ADDR_BASE : `PARS_PHY_ADDR_BASE + 5'h01;
            wire       sel_port2 = (g != 0);
            wire       mi_wr = miim_req_i & miim_we_i;
            wire       sw_wr = sw_req_i & sw_we_i;
            wire       mi_adv_wr = mi_wr & miim_hit(phy_select_address_i,
                                     register_select_address_i, phy_addr, `PARS_REG_ADV);
            wire       mi_cd_wr = mi_wr & miim_hit(phy_select_address_i,
                                    register_select_address_i, phy_addr, `PARS_REG_CDIAG);
            wire       sw_adv_wr = sw_wr & sw_hit(sw_addr_i, `PARS_SW_ADV, sel_port2);
            wire       sw_cd_wr = sw_wr & sw_hit(sw_addr_i, `PARS_SW_CD_CTRL, sel_port2);
            reg  [4:0] adv_reg;
            reg  [4:0] partner_reg;
            wire       start;

            // writable ability bits, PHY-side write wins a same-cycle clash
            always @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    adv_reg <= `PARS_ADV_RST;
                end else if (mi_adv_wr) begin
                    adv_reg <= {miim_wdata_i[`PARS_ADV_PAUSE_BIT],
                                miim_wdata_i[`PARS_ADV_F100_BIT],
                                miim_wdata_i[`PARS_ADV_H100_BIT],
                                miim_wdata_i[`PARS_ADV_F10_BIT],
                                miim_wdata_i[`PARS_ADV_H10_BIT]};
                end else if (sw_adv_wr) begin
                    // 8-bit alias of the same bits
                    adv_reg <= sw_wdata_i[4:0];
                end
            end

            // partner copy, loaded only by the negotiation engine
            always @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    partner_reg <= `PARS_PARTNER_RST;
                end else if (partner_update_i[g]) begin
                    partner_reg <= partner_ability_i[5*g +: 5];
                end
            end

            // only a written one launches; writing zero is ignored
            assign start = (mi_cd_wr & miim_wdata_i[`PARS_CD_START_BIT])
                         | (sw_cd_wr & sw_wdata_i[`PARS_SW_CD_START_BIT]);

            pars_cdiag #(
                .TIMEOUT (CDIAG_TIMEOUT)
            ) u_cdiag (
                .clk_sys_i   (clk_sys_i),
                .rst_b_i     (rst_b_i),
                .start_i     (start),
                .busy_o      (busy_all[g]),
                .fe_start_o  (cdiag_fe_start_o[g]),
                .fe_done_i   (cdiag_fe_done_i[g]),
                .fe_result_i (cdiag_fe_result_i[2*g +: 2]),
                .fe_short_i  (cdiag_fe_short_i[g]),
                .fe_count_i  (cdiag_fe_count_i[9*g +: 9]),
                .result_o    (result_all[2*g +: 2]),
                .short_o     (short_all[g]),
                .count_o     (count_all[9*g +: 9])
            );

            assign adv_all[5*g +: 5]     = adv_reg;
            assign partner_all[5*g +: 5] = partner_reg;
        end
    endgenerate

    // PHY-side read mux; unmapped addresses read as zero
    reg [15:0] miim_rdata_next;
    integer    i;

    always @* begin
        miim_rdata_next = 16'h0000;
        for (i = 0; i < 2; i = i + 1) begin
            if (phy_select_address_i == (`PARS_PHY_ADDR_BASE + i[4:0])) begin
                case (register_select_address_i)
                    `PARS_REG_ADV: begin
                        miim_rdata_next = {5'h00, adv_all[5*i+4], 1'b0,
                                           adv_all[5*i+3], adv_all[5*i+2],
                                           adv_all[5*i+1], adv_all[5*i],
                                           `PARS_ADV_SELECTOR};
                    end
                    `PARS_REG_PARTNER: begin
                        miim_rdata_next = {5'h00, partner_all[5*i+4], 1'b0,
                                           partner_all[5*i+3], partner_all[5*i+2],
                                           partner_all[5*i+1], partner_all[5*i],
                                           5'h00};
                    end
                    `PARS_REG_CDIAG: begin
                        // start bit is the live busy flag
                        miim_rdata_next = {busy_all[i], result_all[2*i +: 2],
                                           short_all[i], 3'h0, count_all[9*i +: 9]};
                    end
                    default: begin
                        miim_rdata_next = 16'h0000;
                    end
                endcase
            end
        end
    end

    // Switch-side read mux, 8-bit aliases of the same state
    reg [7:0] sw_rdata_next;
    integer   j;

    always @* begin
        sw_rdata_next = 8'h00;
        for (j = 0; j < 2; j = j + 1) begin
            if (sw_hit(sw_addr_i, `PARS_SW_ADV, j != 0)) begin
                sw_rdata_next = {3'h0, adv_all[5*j +: 5]};
            end
            if (sw_hit(sw_addr_i, `PARS_SW_PARTNER, j != 0)) begin
                sw_rdata_next = {3'h0, partner_all[5*j +: 5]};
            end
            if (sw_hit(sw_addr_i, `PARS_SW_CD_CTRL, j != 0)) begin
                sw_rdata_next = {short_all[j], result_all[2*j +: 2], busy_all[j],
                                 3'h0, count_all[9*j+8]};
            end
            if (sw_hit(sw_addr_i, `PARS_SW_CD_COUNT, j != 0)) begin
                sw_rdata_next = count_all[9*j +: 8];
            end
        end
    end

    // Answers one cycle after the request, data held until the next read request
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            miim_rdata_o <= 16'h0000;
            miim_ack_o   <= 1'b0;
            sw_rdata_o   <= 8'h00;
            sw_ack_o     <= 1'b0;
        end else begin
            miim_ack_o <= miim_req_i;
            sw_ack_o   <= sw_req_i;
            if (miim_req_i && !miim_we_i) begin
                miim_rdata_o <= miim_rdata_next;
            end
            if (sw_req_i && !sw_we_i) begin
                sw_rdata_o <= sw_rdata_next;
            end
        end
    end

endmodule
